/* hw/bus_agent_end.sv */
/*
  Bus agent end: reset entry and exit, strap capture at reset
  release, response status and parity reception, thermal alert.
  Assumes the link lines arrive from another domain and are
  synchronised here; the sensor flag comes from logic on clk.
*/
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Reset clears state, invalidates cache, no write-back
// - Platform holds power-on reset at least 1 ms
// - Outputs released within two clocks of reset
// - Reset lasts no more than 10 ms
// - Capture strap levels when reset releases
// - Response agent drives the status lines
// - Parity driven together with status lines
// - Parity high for even low-line count
// - All-high idle status counts as correct parity
// - Open-drain active-low thermal alert output
// - Power good return followed by 1 ms reset
module bus_agent_end
  import bus_reset_pkg::*;
#(
  parameter int CW = CFG_W,
  parameter int DW = DEV_OUT_W,
  parameter int LINES = CACHE_LINES
) (
  input wire logic clk,
  input wire logic rst,
  bus_reset_if.agent link,
  // User side: bus output request
  input wire logic bus_drive_en,
  input wire logic [DW-1:0] bus_value_n,
  // User side: cache line tracking
  input wire logic fill_en,
  input wire logic [$clog2(LINES)-1:0] fill_idx,
  input wire logic dirty_en,
  input wire logic [$clog2(LINES)-1:0] dirty_idx,
  input wire logic evict_en,
  input wire logic [$clog2(LINES)-1:0] evict_idx,
  output logic [LINES-1:0] line_valid,
  output logic writeback_req,
  // User side: status
  output logic in_reset,
  output logic [CW-1:0] cfg_opts,
  output logic cfg_valid,
  output logic resp_valid,
  output logic [RESP_W-1:0] resp_status,
  output logic resp_parity_err,
  // User side: sensor over temperature flag
  input wire logic temp_over
);

  localparam int SW = 3 + RESP_W + CW; // Synchronised line count
  localparam int IW = $clog2(LINES);

  logic [SW-1:0] sync1_r;       // First synchroniser stage
  logic [SW-1:0] sync2_r;       // Second stage, the only reader of sync1_r
  logic reset_n_s;              // Synchronised reset line
  logic power_ok_s;             // Synchronised power good
  logic [RESP_W-1:0] rs_n_s;    // Synchronised status lines
  logic rsp_n_s;                // Synchronised parity line
  logic [CW-1:0] cfg_n_s;       // Synchronised strap lines
  logic reset_n_prev_r;         // Last cycle's reset line, for release edge
  logic drive_r;                // Outputs wanted by the user
  logic [DW-1:0] out_r;         // Output levels
  logic [LINES-1:0] valid_r;    // Line valid bits
  logic [LINES-1:0] dirty_r;    // Line modified bits
  logic wb_r;                   // Write-back pulse
  logic [CW-1:0] cfg_r;         // Captured straps
  logic cfg_valid_r;            // Straps captured since reset
  logic resp_valid_r;           // Status lines seen non-idle, three clocks after they were driven
  logic [RESP_W-1:0] resp_r;    // Status, active high
  logic perr_r;                 // Parity error pulse
  logic alert_r;                // Alert asserted
  logic rs_idle;                // Status lines released
  logic parity_ok;              // Parity matches status

  // Two-flop synchroniser for all link inputs. Reset and power good
  // start at their in-reset levels so that no false release edge (and
  // no early drive or strap capture) follows local reset; the other
  // lines start at their released, pulled-up level.
  always_ff @(posedge clk) begin
    if (rst) begin
      sync1_r <= {2'b00, {(SW-2){LINE_HIGH}}};
      sync2_r <= {2'b00, {(SW-2){LINE_HIGH}}};
    end else begin
      sync1_r <= {link.reset_n, link.power_ok_in, link.resp_status_n,
                  link.resp_status_parity_n, link.cfg_n};
      sync2_r <= sync1_r;
    end
  end

  // Split the synchronised vector
  assign reset_n_s = sync2_r[SW-1];
  assign power_ok_s = sync2_r[SW-2];
  assign rs_n_s = sync2_r[SW-3 -: RESP_W];
  assign rsp_n_s = sync2_r[CW];
  assign cfg_n_s = sync2_r[CW-1:0];

  // Reset as seen by the agent: local, link reset or lost power.
  // The platform keeps the link reset low long enough after power returns.
  assign in_reset = rst | ~reset_n_s | ~power_ok_s;

  // Remember the reset line to find its release edge
  always_ff @(posedge clk) begin
    if (rst) begin
      reset_n_prev_r <= 1'b0;
    end else begin
      reset_n_prev_r <= reset_n_s;
    end
  end

  // Output request; dropped as soon as reset is seen
  always_ff @(posedge clk) begin
    if (in_reset) begin
      drive_r <= 1'b0;
      out_r <= '1;
    end else begin
      drive_r <= bus_drive_en;
      out_r <= bus_value_n;
    end
  end

  // Enable is gated straight by reset: the two synchroniser edges are
  // the whole delay, so the release meets the two-clock bound.
  assign link.dev_oe = drive_r & ~in_reset;
  assign link.dev_out_n = out_r;

  // Cache tracking; reset drops every line without a write-back
  always_ff @(posedge clk) begin
    if (in_reset) begin
      valid_r <= '0;
      dirty_r <= '0;
    end else begin
      if (fill_en) begin
        valid_r[fill_idx] <= 1'b1;
        dirty_r[fill_idx] <= 1'b0;
      end
      if (dirty_en && valid_r[dirty_idx]) begin
        dirty_r[dirty_idx] <= 1'b1;
      end
      // Eviction wins over a fill of the same line in the same cycle
      if (evict_en) begin
        valid_r[evict_idx] <= 1'b0;
        dirty_r[evict_idx] <= 1'b0;
      end
    end
  end

  // Write-back only for a modified line evicted outside reset
  always_ff @(posedge clk) begin
    if (in_reset) begin
      wb_r <= 1'b0;
    end else begin
      wb_r <= evict_en & valid_r[evict_idx] & dirty_r[evict_idx];
    end
  end

  assign line_valid = valid_r;
  assign writeback_req = wb_r;

  // Strap capture on the release edge of the link reset. Straps pass
  // the same synchroniser as reset, so both are aligned here.
  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_r <= '0;
      cfg_valid_r <= 1'b0;
    end else if (!reset_n_s) begin
      cfg_valid_r <= 1'b0;
    end else if (!reset_n_prev_r) begin
      cfg_r <= ~cfg_n_s;
      cfg_valid_r <= 1'b1;
    end
  end

  assign cfg_opts = cfg_r;
  assign cfg_valid = cfg_valid_r;

  // Parity check of the received response
  resp_parity_check u_parity (
    .status_n(rs_n_s),
    .parity_n(rsp_n_s),
    .idle(rs_idle),
    .parity_ok(parity_ok)
  );

  // Response status capture; idle lines give no response and no error
  always_ff @(posedge clk) begin
    if (in_reset) begin
      resp_valid_r <= 1'b0;
      resp_r <= '0;
      perr_r <= 1'b0;
    end else begin
      resp_valid_r <= ~rs_idle;
      resp_r <= ~rs_n_s;
      perr_r <= ~parity_ok;
    end
  end

  assign resp_valid = resp_valid_r;
  assign resp_status = resp_r;
  assign resp_parity_err = perr_r;

  // Thermal alert follows the sensor, independent of bus reset,
  // since the alert must still reach the system while held in reset.
  always_ff @(posedge clk) begin
    if (rst) begin
      alert_r <= 1'b0;
    end else begin
      alert_r <= temp_over;
    end
  end

  // Open drain: only ever pulls low, the pull-up gives the high
  assign link.alert_out_n = 1'b0;
  assign link.alert_oe = alert_r;

endmodule : bus_agent_end
`default_nettype wire

/* hw/bus_reset_if.sv */
/*
  Link between the bus agent end and the platform/response end.
  Open-drain style lines apart from reset_n and power_ok_in, which the platform
  drives directly: each driver gives output and enable, the interface
  resolves the wire with a pull-up when nobody drives.
*/
`timescale 1ns/1ps
`default_nettype none
interface bus_reset_if #(
  parameter int CW = bus_reset_pkg::CFG_W,
  parameter int DW = bus_reset_pkg::DEV_OUT_W
);
  import bus_reset_pkg::*;

  logic reset_n;                  // Platform reset, active low
  logic power_ok_in;              // Power and clocks stable
  logic [CW-1:0] cfg_out_n;       // Strap levels from the platform
  logic cfg_oe;                   // Platform drives the straps
  logic [RESP_W-1:0] rs_out_n;    // Response status drive
  logic rs_oe;                    // Response agent drives status
  logic rsp_out_n;                // Response parity drive
  logic rsp_oe;                   // Response agent drives parity
  logic [DW-1:0] dev_out_n;       // Agent bus outputs
  logic dev_oe;                   // Agent drives its bus outputs
  logic alert_out_n;              // Thermal alert drive level
  logic alert_oe;                 // Agent pulls the alert low

  // Resolved wire levels, pulled up when released
  logic [CW-1:0] cfg_n;
  logic [RESP_W-1:0] resp_status_n;
  logic resp_status_parity_n;
  logic [DW-1:0] bus_n;
  logic thermal_alert_n;

  assign cfg_n = cfg_oe ? cfg_out_n : {CW{LINE_HIGH}};
  assign resp_status_n = rs_oe ? rs_out_n : RESP_IDLE_N;
  assign resp_status_parity_n = rsp_oe ? rsp_out_n : LINE_HIGH;
  assign bus_n = dev_oe ? dev_out_n : {DW{LINE_HIGH}};
  assign thermal_alert_n = alert_oe ? alert_out_n : LINE_HIGH;

  modport agent (
    input reset_n, power_ok_in, cfg_n, resp_status_n,
    input resp_status_parity_n,
    output dev_out_n, dev_oe, alert_out_n, alert_oe
  );

  modport platform (
    output reset_n, power_ok_in, cfg_out_n, cfg_oe,
    output rs_out_n, rs_oe, rsp_out_n, rsp_oe,
    input bus_n, thermal_alert_n
  );
endinterface : bus_reset_if
`default_nettype wire

/* hw/bus_reset_pkg.sv */
/*
  Shared constants, types and the response parity function for the
  bus reset and response parity pair of ends.
  Assumes a single 100 MHz clock on both ends.
*/
package bus_reset_pkg;

  // Clock rate in MHz, period 10 ns
  localparam int CLK_MHZ = 100;
  // Least power-on reset hold, in ms
  localparam int PON_RESET_MS = 1;
  // Longest reset hold after power good, in ms
  localparam int MAX_RESET_MS = 10;
  // Cycle counts derived from the times above
  localparam int PON_RESET_CYCLES = PON_RESET_MS * 1000 * CLK_MHZ;
  localparam int MAX_RESET_CYCLES = MAX_RESET_MS * 1000 * CLK_MHZ;
  // Bus clocks allowed from observed reset to released outputs
  localparam int RELEASE_CLKS = 2;
  // Configuration lines stay driven this long after reset release
  localparam int CFG_HOLD_CLKS = 2;

  // Widths
  localparam int RESP_W = 3;
  localparam int CFG_W = 4;
  localparam int DEV_OUT_W = 8;
  localparam int CACHE_LINES = 16;

  // Idle pattern of the response status lines (nobody drives them)
  localparam logic [RESP_W-1:0] RESP_IDLE_N = 3'h7;
  // Level of a released active-low line
  localparam logic LINE_HIGH = 1'h1;

  // Platform sequencer states
  typedef enum logic [1:0] {
    ST_OFF,
    ST_HOLD,
    ST_RUN
  } plat_state_e;

  // Correct parity level: high for an even count of low lines
  function automatic logic resp_parity_n_f(input logic [RESP_W-1:0] status_n);
    resp_parity_n_f = ~(^(~status_n));
  endfunction : resp_parity_n_f

endpackage : bus_reset_pkg

/* hw/platform_resp_end.sv */
/*
  Platform and response agent end: power good and reset sequencing,
  strap drive around reset, response status with parity.
  Assumes supply_ok tells that supplies and bus clock are stable.
*/
`timescale 1ns/1ps
`default_nettype none
module platform_resp_end
  import bus_reset_pkg::*;
#(
  parameter int CW = CFG_W,
  parameter int PON_CYCLES = PON_RESET_CYCLES,
  parameter int MAX_CYCLES = MAX_RESET_CYCLES
) (
  input wire logic clk,
  input wire logic rst,
  bus_reset_if.platform link,
  input wire logic supply_ok,
  input wire logic reset_req,
  input wire logic [CW-1:0] cfg_opts,
  input wire logic resp_req,
  input wire logic [RESP_W-1:0] resp_code,
  output logic reset_active,
  output logic thermal_alert
);

  // Hold never exceeds the longest allowed reset
  localparam int HOLD = (PON_CYCLES < MAX_CYCLES) ? PON_CYCLES : MAX_CYCLES;
  localparam int HW = $clog2(HOLD + 1);
  localparam int CHW = $clog2(CFG_HOLD_CLKS + 1);

  plat_state_e state_r;          // Sequencer state
  logic [HW-1:0] cnt_r;          // Reset hold counter
  logic [CHW-1:0] cfg_hold_r;    // Strap hold after release
  logic [RESP_W-1:0] rs_r;       // Status drive, active low
  logic rsp_r;                   // Parity drive
  logic resp_oe_r;               // Response lines driven
  logic [1:0] alert_sync_r;      // Alert synchroniser

  // Power good and reset sequencer
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= ST_OFF;
      cnt_r <= '0;
    end else if (!supply_ok) begin
      state_r <= ST_OFF; // Power good may drop at any time
      cnt_r <= '0;
    end else begin
      case (state_r)
        ST_OFF: begin
          state_r <= ST_HOLD;
          cnt_r <= '0;
        end
        ST_HOLD: begin
          if (cnt_r == HW'(HOLD - 1)) begin
            state_r <= ST_RUN;
          end else begin
            cnt_r <= cnt_r + 1'b1;
          end
        end
        ST_RUN: begin
          if (reset_req) begin
            state_r <= ST_HOLD;
            cnt_r <= '0;
          end
        end
        default: begin
          state_r <= ST_OFF;
        end
      endcase
    end
  end

  assign link.power_ok_in = (state_r != ST_OFF);
  assign link.reset_n = (state_r == ST_RUN);
  assign reset_active = (state_r != ST_RUN);

  // Straps driven during reset and a little after release
  always_ff @(posedge clk) begin
    if (rst || state_r != ST_RUN) begin
      cfg_hold_r <= CHW'(CFG_HOLD_CLKS);
    end else if (cfg_hold_r != '0) begin
      cfg_hold_r <= cfg_hold_r - 1'b1;
    end
  end

  assign link.cfg_out_n = ~cfg_opts;
  assign link.cfg_oe = (cfg_hold_r != '0);

  // Response drive: status and its parity in the same cycle
  always_ff @(posedge clk) begin
    if (rst || state_r != ST_RUN) begin
      resp_oe_r <= 1'b0;
      rs_r <= RESP_IDLE_N;
      rsp_r <= LINE_HIGH;
    end else begin
      resp_oe_r <= resp_req;
      rs_r <= ~resp_code;
      rsp_r <= resp_parity_n_f(~resp_code);
    end
  end

  assign link.rs_out_n = rs_r;
  assign link.rs_oe = resp_oe_r;
  assign link.rsp_out_n = rsp_r;
  assign link.rsp_oe = resp_oe_r;

  // Alert line comes from the other end: two flops first
  always_ff @(posedge clk) begin
    if (rst) begin
      alert_sync_r <= 2'h0;
    end else begin
      alert_sync_r <= {alert_sync_r[0], ~link.thermal_alert_n};
    end
  end

  assign thermal_alert = alert_sync_r[1];

endmodule : platform_resp_end
`default_nettype wire

/* hw/resp_parity_check.sv */
/*
  Response parity checker: compares the parity line with the level
  expected from the three status lines.
  Assumes both inputs are already synchronised to clk.
*/
`timescale 1ns/1ps
`default_nettype none
module resp_parity_check
  import bus_reset_pkg::*;
(
  input wire logic [RESP_W-1:0] status_n,
  input wire logic parity_n,
  output logic idle,
  output logic parity_ok
);

  // Released lines read all high, which is itself a legal parity
  assign idle = (status_n == RESP_IDLE_N);

  // Idle status with high parity falls out of the same check
  assign parity_ok = (parity_n == resp_parity_n_f(status_n));

endmodule : resp_parity_check
`default_nettype wire

/* verif/bus_reset_and_response_parity_bench.sv */
/*
  Bench joining the agent end and the platform end through their link.
  Assumes a shortened reset hold of 20 cycles and a 50 cycle ceiling.
*/
`timescale 1ns/1ps
`default_nettype none
module bus_reset_and_response_parity_bench;
  import bus_reset_pkg::*;

  localparam int PON = 20;  // Short hold keeps the run brief
  localparam int MAX = 50;  // Short ceiling on reset
  localparam int LIMIT = 2000;  // Timeout in cycles

  logic clk = 1'h0;
  logic rst = 1'h1;
  logic supply_ok = 1'h0;
  logic reset_req = 1'h0;
  logic [CFG_W-1:0] cfg_set = 4'h5;  // Active-high strap value
  logic resp_req = 1'h0;
  logic [RESP_W-1:0] resp_code = 3'h0;
  logic bus_drive_en = 1'h0;
  logic [DEV_OUT_W-1:0] bus_value_n = 8'h00;
  logic fill_en = 1'h0, dirty_en = 1'h0, evict_en = 1'h0;
  logic [3:0] fill_idx = 4'h0, dirty_idx = 4'h0, evict_idx = 4'h0;
  logic temp_over = 1'h0;
  logic [CACHE_LINES-1:0] line_valid;
  logic writeback_req, in_reset, cfg_valid, resp_valid, resp_parity_err, reset_active, thermal_alert;
  logic [CFG_W-1:0] cfg_opts;
  logic [RESP_W-1:0] resp_status;
  int num_errors = 0, n_compared = 0, cycles = 0, wb_seen = 0;

  bus_reset_if link ();
  bus_agent_end i_bus_agent_end (.clk(clk), .rst(rst), .link(link.agent), .bus_drive_en(bus_drive_en),
    .bus_value_n(bus_value_n), .fill_en(fill_en), .fill_idx(fill_idx), .dirty_en(dirty_en),
    .dirty_idx(dirty_idx), .evict_en(evict_en), .evict_idx(evict_idx), .line_valid(line_valid),
    .writeback_req(writeback_req), .in_reset(in_reset), .cfg_opts(cfg_opts), .cfg_valid(cfg_valid),
    .resp_valid(resp_valid), .resp_status(resp_status), .resp_parity_err(resp_parity_err),
    .temp_over(temp_over));
  platform_resp_end #(.PON_CYCLES(PON), .MAX_CYCLES(MAX)) i_platform_resp_end (.clk(clk), .rst(rst),
    .link(link.platform), .supply_ok(supply_ok), .reset_req(reset_req), .cfg_opts(cfg_set),
    .resp_req(resp_req), .resp_code(resp_code), .reset_active(reset_active), .thermal_alert(thermal_alert));
  bus_reset_chk #(.PON_CYCLES(PON), .MAX_CYCLES(MAX)) i_bus_reset_chk (.clk(clk), .rst(rst),
    .reset_n(link.reset_n), .power_ok_in(link.power_ok_in), .cfg_oe(link.cfg_oe),
    .resp_status_n(link.resp_status_n), .resp_status_parity_n(link.resp_status_parity_n),
    .rs_oe(link.rs_oe), .rsp_oe(link.rsp_oe), .dev_oe(link.dev_oe), .alert_oe(link.alert_oe),
    .thermal_alert_n(link.thermal_alert_n));

  // 100 MHz clock
  initial begin
    forever #5 clk = ~clk;
  end

  // Cut a hang short; count write-back pulses so reset can be shown clean
  always @(posedge clk) begin
    cycles++;
    if (writeback_req === 1'h1) begin
      wb_seen++;
    end
    if (cycles == LIMIT) begin
      num_errors++;
      end_sim();
    end
  end

  // Inputs always change 1 ns after the edge, clear of sampling
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic cmp(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      $display("[FAIL] %0t %s", $time, what);
      num_errors++;
    end
  endtask : cmp

  // Bounded wait until both ends are out of reset, then past strap capture
  task automatic wait_ready();
    int k;
    k = 0;
    while ((in_reset !== 1'h0 || reset_active !== 1'h0) && k < 200) begin
      tick(1);
      k++;
    end
    cmp(k < 200, 1'h1, "ends never left reset");
    tick(2);
  endtask : wait_ready

  task automatic t_power_up();
    supply_ok = 1'h1;
    wait_ready();
    cmp(cfg_valid, 1'h1, "config not valid");
    cmp(cfg_opts, cfg_set, "config capture");
  endtask : t_power_up

  // Every status code; code 0 leaves the lines idle high
  task automatic t_resp();
    logic [2:0] code_n;
    logic par_n;
    for (int c = 0; c < 8; c++) begin
      resp_req = 1'h1;
      resp_code = c[2:0];
      code_n = ~resp_code;
      par_n = ~(^resp_code);
      tick(1);
      resp_req = 1'h0;
      cmp(link.resp_status_n, code_n, "status lines");
      cmp(link.resp_status_parity_n, par_n, "parity line");
      tick(3);
      cmp(resp_valid, c != 0, "response valid");
      cmp(resp_status, (c != 0) ? resp_code : 3'h0, "response code");
      cmp(resp_parity_err, 1'h0, "false parity error");
    end
  endtask : t_resp

  // Bus reset in mid-run with a dirty line and driven outputs
  task automatic t_reset();
    bus_value_n = 8'h5a;
    bus_drive_en = 1'h1;
    fill_en = 1'h1;
    fill_idx = 4'h3;
    tick(1);
    fill_idx = 4'h5;
    tick(1);
    fill_en = 1'h0;
    dirty_en = 1'h1;
    dirty_idx = 4'h3;
    tick(1);
    dirty_en = 1'h0;
    cmp(line_valid, 16'h0028, "lines filled");
    cmp(link.bus_n, 8'h5a, "bus drive");
    cfg_set = 4'ha;
    wb_seen = 0;
    reset_req = 1'h1;
    tick(1);
    reset_req = 1'h0;
    tick(4);
    cmp(link.bus_n, 8'hff, "outputs not released");
    cmp(line_valid, 16'h0000, "cache kept");
    cmp(in_reset, 1'h1, "link reset unseen");
    cmp(cfg_valid, 1'h0, "config valid kept in reset");
    wait_ready();
    cmp(wb_seen[15:0], 16'h0000, "write-back in reset");
    cmp(cfg_opts, 4'ha, "config recapture");
    cmp(link.bus_n, 8'h5a, "drive not resumed");
    cfg_set = 4'h3;
    fill_en = 1'h1;
    tick(1);
    fill_en = 1'h0;
    dirty_en = 1'h1;
    dirty_idx = 4'h5;
    tick(1);
    dirty_en = 1'h0;
    evict_en = 1'h1;
    evict_idx = 4'h5;
    tick(1);
    evict_en = 1'h0;
    tick(1);
    cmp(wb_seen[15:0], 16'h0001, "no write-back on evict");
    cmp(cfg_opts, 4'ha, "config changed after capture");
  endtask : t_reset

  task automatic t_alert();
    temp_over = 1'h1;
    tick(4);
    cmp(link.thermal_alert_n, 1'h0, "alert not low");
    cmp(thermal_alert, 1'h1, "alert not seen");
    temp_over = 1'h0;
    tick(4);
    cmp(link.thermal_alert_n, 1'h1, "alert not released");
    cmp(thermal_alert, 1'h0, "alert release unseen");
  endtask : t_alert

  // Power good drops and returns while the agent drives
  task automatic t_power_drop();
    supply_ok = 1'h0;
    tick(4);
    cmp(in_reset, 1'h1, "power drop unseen");
    cmp(link.bus_n, 8'hff, "outputs not released");
    cmp(cfg_valid, 1'h0, "config valid kept at power drop");
    supply_ok = 1'h1;
    wait_ready();
    cmp(cfg_opts, 4'h3, "config after power return");
  endtask : t_power_drop

  task automatic end_sim();
    if (num_errors == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim

  // Reset for 8 cycles, then the scenarios in turn
  initial begin
    tick(8);
    rst = 1'h0;
    t_power_up();
    t_resp();
    t_reset();
    t_alert();
    t_power_drop();
    end_sim();
  end
endmodule : bus_reset_and_response_parity_bench
`default_nettype wire

/* verif/bus_reset_chk.sv */
/*
  Checker for the link between the agent end and the platform end.
  Assumes plain link signals, one clock and a synchronous high reset.
*/
`timescale 1ns/1ps
`default_nettype none
module bus_reset_chk
  import bus_reset_pkg::*;
#(
  parameter int PON_CYCLES = 20,
  parameter int MAX_CYCLES = 50
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic reset_n,
  input wire logic power_ok_in,
  input wire logic cfg_oe,
  input wire logic [RESP_W-1:0] resp_status_n,
  input wire logic resp_status_parity_n,
  input wire logic rs_oe,
  input wire logic rsp_oe,
  input wire logic dev_oe,
  input wire logic alert_oe,
  input wire logic thermal_alert_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  // Reset cycles seen since power good rose
  int hold_r;

  // Restart when power drops or reset lifts, so each hold is measured alone
  always_ff @(posedge clk) begin
    if (rst || !power_ok_in || reset_n) begin
      hold_r <= 0;
    end else begin
      hold_r <= hold_r + 1;
    end
  end

  // Reset seen low on three samples in a row, past the agent's sync lag
  sequence s_rst_held;
    !reset_n [*3];
  endsequence

  // Reset just lifted
  sequence s_rst_lift;
    $rose(reset_n);
  endsequence

  AST_OUT_RELEASE: assert property ($fell(reset_n) |-> ##[0:2] !dev_oe)
    else $error("outputs still driven two clocks after reset");
  AST_HELD_QUIET: assert property (s_rst_held |-> !dev_oe)
    else $error("outputs driven during reset");
  AST_LIFT_QUIET: assert property (s_rst_lift |-> !dev_oe [*3])
    else $error("outputs driven before reset release was seen");
  AST_PARITY_PAIR: assert property ((rs_oe || rsp_oe) |-> (rs_oe && rsp_oe))
    else $error("parity and status not driven together");
  AST_PARITY_EVEN: assert property (rs_oe |-> resp_status_parity_n == ~(^(~resp_status_n)))
    else $error("wrong response parity level");
  AST_IDLE_OK: assert property (resp_status_n == 3'h7 |-> resp_status_parity_n)
    else $error("idle status without high parity");
  AST_RESP_IN_RUN: assert property (rs_oe |-> $past(reset_n))
    else $error("response driven while bus in reset");
  AST_PON_HOLD: assert property (s_rst_lift |-> hold_r >= PON_CYCLES)
    else $error("reset released too early");
  AST_MAX_HOLD: assert property (hold_r <= MAX_CYCLES)
    else $error("reset held too long after power good");
  AST_CFG_DRIVEN: assert property (s_rst_lift |-> cfg_oe [*2])
    else $error("straps released at reset release");
  AST_ALERT_LOW: assert property (alert_oe |-> !thermal_alert_n)
    else $error("alert enable without low line");
endmodule : bus_reset_chk
`default_nettype wire
